// ---- msrh_board.sv ----
// Board model: reset source and pulled-up open-drain wire
`timescale 1ns/1ps
module msrh_board #(
    parameter int HOLD_CYC = 20  // Reset hold, scaled down from milliseconds
) (
    input  wire logic mclk,
    input  wire logic rx_hb_pin_oe,
    input  wire logic reset_req,
    output logic      hard_reset_n,
    output logic      rx_hb_pin_i
);
    int cnt_q = 0;  // Cycles since reset was last asserted, held once it reaches HOLD_CYC
    always_ff @(posedge mclk) begin
        if (reset_req) cnt_q <= 0;
        else if (cnt_q < HOLD_CYC) cnt_q <= cnt_q + 1;
    end
    // Pull-up wins whenever the device releases the wire
    always_comb begin
        hard_reset_n = (cnt_q >= HOLD_CYC);
        rx_hb_pin_i  = !rx_hb_pin_oe;
    end
endmodule : msrh_board

// ---- msrh_pkg.sv ----
// Package of constants and carrier types for the mode strap, reset and heartbeat block
package msrh_pkg;

    // Clock rate in Hz (system clock mclk)
    localparam int unsigned CLK_HZ          = 20_000_000;

    // Strap hold time for monitor entry, in seconds
    localparam int unsigned STRAP_HOLD_S    = 5;
    // Strap hold time in cycles (least time, exact here)
    localparam int unsigned STRAP_HOLD_CYC  = STRAP_HOLD_S * CLK_HZ;

    // Heartbeat period in milliseconds
    localparam int unsigned BEAT_PERIOD_MS  = 40;
    // Half period in cycles, 50 percent duty
    localparam int unsigned BEAT_HALF_CYC   = (BEAT_PERIOD_MS * (CLK_HZ / 1000)) / 2;

    // Width of the heartbeat half-period counter
    localparam int unsigned BEAT_CNT_W      = 20;
    // Width of the strap hold counter
    localparam int unsigned STRAP_CNT_W     = 27;

    // Number of sockets watched for new data
    localparam int unsigned NUM_SOCKETS     = 10;

    // Reset level of the transmit pin; reset and idle level of the programming receive line
    localparam logic        PIN_IDLE        = 1'b1;

    // Operating modes after strap evaluation
    typedef enum logic [1:0] {
        MSRH_MODE_APP,
        MSRH_MODE_AUTOBAUD,
        MSRH_MODE_MONITOR
    } msrh_mode_t;

    // Socket status from firmware logic
    typedef struct packed {
        logic [NUM_SOCKETS-1:0] arrived;   // Pulse: new data landed per socket
        logic [NUM_SOCKETS-1:0] read_done; // Pulse: host read a socket
    } msrh_sock_t;

    // Loader transmit bit for monitor mode and firmware alive flag for the heartbeat
    typedef struct packed {
        logic tx;    // Serial transmit bit from the loader
        logic fw_ok; // Firmware alive indication
    } msrh_app_t;

endpackage : msrh_pkg

// ---- msrh_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module msrh_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);

    logic meta_q; // First stage, read only by the second

    // Two stages to settle a pin from outside the clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : msrh_sync

// ---- msrh_top.sv ----
// Mode strap evaluation, hard reset, heartbeat and new-data indication
`timescale 1ns/1ps
module msrh_top (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 hard_reset_n,
    input  wire logic                 mode_strap_n,
    input  wire logic                 rx_hb_pin_i,
    input  wire logic                 bridge_active,
    input  wire msrh_pkg::msrh_sock_t sock,
    input  wire msrh_pkg::msrh_app_t  app,
    output logic                      rx_hb_pin_o,
    output logic                      rx_hb_pin_oe,
    output logic                      tx_nd_pin,
    output logic                      prog_serial_rx,
    output logic                      field_reprogram_mode,
    output logic                      autobaud_start,
    output logic                      bridge_exit,
    output logic                      mode_valid
);

    // Synchronised pins
    logic                             hrst_n_s;   // Hard reset, synced
    logic                             strap_n_s;  // Strap, synced
    logic                             rx_s;       // Shared pin input, synced

    // Hard reset pin, synced before use
    msrh_sync #(.RST_VAL(1'b0)) u_sync_hrst (
        .mclk (mclk),
        .rst  (rst),
        .din  (hard_reset_n),
        .dout (hrst_n_s)
    );

    // Strap has a pull-up, so idle high
    msrh_sync #(.RST_VAL(1'b1)) u_sync_strap (
        .mclk (mclk),
        .rst  (rst),
        .din  (mode_strap_n),
        .dout (strap_n_s)
    );

    // Shared pin read back as receive data
    msrh_sync #(.RST_VAL(1'b1)) u_sync_rx (
        .mclk (mclk),
        .rst  (rst),
        .din  (rx_hb_pin_i),
        .dout (rx_s)
    );

    // Combined clear: system reset or pin low
    logic                             clr;
    assign clr = rst | ~hrst_n_s;

    // Strap evaluation state machine
    typedef enum logic [1:0] {
        MSRH_ST_POWERUP,
        MSRH_ST_TIMING,
        MSRH_ST_DONE
    } msrh_st_t;

    msrh_st_t                         st_q;       // Evaluation state
    logic [msrh_pkg::STRAP_CNT_W-1:0] hold_q;     // Strap low cycle count
    msrh_pkg::msrh_mode_t             mode_q;     // Chosen mode
    logic                             strap_d1_q; // Strap delayed, for edge

    // Strap sampled in the power-up and timing states; the count is the hold length
    always_ff @(posedge mclk) begin
        if (clr) begin
            st_q   <= MSRH_ST_POWERUP;
            hold_q <= '0;
            mode_q <= msrh_pkg::MSRH_MODE_APP;
        end else begin
            case (st_q)
                // First cycle after release decides strap state
                MSRH_ST_POWERUP: begin
                    if (!strap_n_s) begin
                        st_q   <= MSRH_ST_TIMING;
                        hold_q <= msrh_pkg::STRAP_CNT_W'(1);
                    end else begin
                        st_q   <= MSRH_ST_DONE;
                        mode_q <= msrh_pkg::MSRH_MODE_APP;
                    end
                end
                MSRH_ST_TIMING: begin
                    if (hold_q >= msrh_pkg::STRAP_CNT_W'(msrh_pkg::STRAP_HOLD_CYC)) begin
                        st_q   <= MSRH_ST_DONE;
                        mode_q <= msrh_pkg::MSRH_MODE_MONITOR;
                    end else if (strap_n_s) begin
                        st_q   <= MSRH_ST_DONE;
                        mode_q <= msrh_pkg::MSRH_MODE_AUTOBAUD;
                    end else begin
                        hold_q <= hold_q + msrh_pkg::STRAP_CNT_W'(1);
                    end
                end
                // Mode latched until next reset
                MSRH_ST_DONE: begin
                    st_q <= MSRH_ST_DONE;
                end
                default: begin
                    st_q <= MSRH_ST_POWERUP;
                end
            endcase
        end
    end

    // Mode status outputs, registered
    always_ff @(posedge mclk) begin
        if (clr) begin
            field_reprogram_mode <= 1'b0;
            mode_valid           <= 1'b0;
            autobaud_start       <= 1'b0;
        end else begin
            field_reprogram_mode <= (st_q == MSRH_ST_DONE) &&
                                    (mode_q == msrh_pkg::MSRH_MODE_MONITOR);
            mode_valid           <= (st_q == MSRH_ST_DONE);
            // One-cycle pulse on entry to auto-baud
            autobaud_start       <= (st_q == MSRH_ST_TIMING) && strap_n_s &&
                (hold_q < msrh_pkg::STRAP_CNT_W'(msrh_pkg::STRAP_HOLD_CYC));
        end
    end

    // Strap falling edge while running, watched whenever bridge_active is high
    always_ff @(posedge mclk) begin
        if (clr) begin
            strap_d1_q  <= 1'b1;
            bridge_exit <= 1'b0;
        end else begin
            strap_d1_q  <= strap_n_s;
            bridge_exit <= bridge_active && strap_d1_q && !strap_n_s;
        end
    end

    // Heartbeat half-period counter; runs on mclk, the 20 MHz system clock
    logic [msrh_pkg::BEAT_CNT_W-1:0]  beat_cnt_q; // Cycles in current half
    logic                             beat_q;     // Heartbeat level
    logic                             app_mode;   // Application running

    assign app_mode = (st_q == MSRH_ST_DONE) && (mode_q != msrh_pkg::MSRH_MODE_MONITOR);

    always_ff @(posedge mclk) begin
        if (clr || !app_mode || !app.fw_ok) begin
            beat_cnt_q <= '0;
            beat_q     <= 1'b0;
        end else if (beat_cnt_q ==
                     msrh_pkg::BEAT_CNT_W'(msrh_pkg::BEAT_HALF_CYC - 1)) begin
            beat_cnt_q <= '0;
            beat_q     <= ~beat_q;
        end else begin
            beat_cnt_q <= beat_cnt_q + msrh_pkg::BEAT_CNT_W'(1);
        end
    end

    // Open-drain pin: drive low for a low beat, release otherwise
    always_ff @(posedge mclk) begin
        if (clr) begin
            rx_hb_pin_o    <= 1'b0;
            rx_hb_pin_oe   <= 1'b0;
            prog_serial_rx <= msrh_pkg::PIN_IDLE;
        end else begin
            rx_hb_pin_o    <= 1'b0;
            // Released in monitor mode, so the pin is an input
            rx_hb_pin_oe   <= app_mode && app.fw_ok && !beat_q;
            prog_serial_rx <= field_reprogram_mode ? rx_s : msrh_pkg::PIN_IDLE;
        end
    end

    // Pending socket data bits, set wins over clear
    logic [msrh_pkg::NUM_SOCKETS-1:0] pend_q;     // Per-socket pending
    logic                             any_read;   // Any socket read now

    assign any_read = |sock.read_done;

    genvar g;
    generate
        for (g = 0; g < msrh_pkg::NUM_SOCKETS; g++) begin : g_sock
            always_ff @(posedge mclk) begin
                if (clr) begin
                    pend_q[g] <= 1'b0;
                end else if (sock.arrived[g]) begin
                    pend_q[g] <= 1'b1;
                end else if (any_read) begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Shared transmit pin: loader data in monitor, new-data flag in app
    always_ff @(posedge mclk) begin
        if (clr) begin
            tx_nd_pin <= msrh_pkg::PIN_IDLE;
        end else if (field_reprogram_mode) begin
            tx_nd_pin <= app.tx;
        end else if (app_mode) begin
            tx_nd_pin <= |pend_q;
        end else begin
            tx_nd_pin <= 1'b0;
        end
    end

endmodule : msrh_top

// ---- msrh_top_properties.sv ----
// Concurrent checks on the strap, reset and heartbeat block ports
`timescale 1ns/1ps
module msrh_props (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 hard_reset_n,
    input wire logic                 mode_strap_n,
    input wire logic                 bridge_active,
    input wire msrh_pkg::msrh_sock_t sock,
    input wire msrh_pkg::msrh_app_t  app,
    input wire logic                 rx_hb_pin_o,
    input wire logic                 rx_hb_pin_oe,
    input wire logic                 tx_nd_pin,
    input wire logic                 prog_serial_rx,
    input wire logic                 field_reprogram_mode,
    input wire logic                 autobaud_start,
    input wire logic                 bridge_exit,
    input wire logic                 mode_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic        ab_q;   // Autobaud chosen since last clear
    int unsigned run_q;  // Cycles the heartbeat has pulled low
    int unsigned low_q;  // Cycles the raw strap has been low
    // Application mode; autobaud pulse and ab_q mask all of auto-baud
    wire app_m = mode_valid && !field_reprogram_mode && !ab_q && !autobaud_start;
    // Autobaud memory, dropped when evaluation restarts
    always_ff @(posedge mclk) begin
        if (rst || (!mode_valid && !autobaud_start)) ab_q <= 1'b0;
        else if (autobaud_start) ab_q <= 1'b1;
    end
    // Run lengths; counts only loosen checks across a hard reset
    always_ff @(posedge mclk) begin
        run_q <= (rst || !rx_hb_pin_oe) ? 0 : run_q + 1;
        low_q <= (rst || mode_strap_n) ? 0 : low_q + 1;
    end
    oe_low_a: assert property (rx_hb_pin_o == 1'b0) else $error("heartbeat pin driven high");
    hb_half_a: assert property (rx_hb_pin_oe |-> run_q < msrh_pkg::BEAT_HALF_CYC)
        else $error("heartbeat half period too long");
    sock_set_a: assert property (app_m && |sock.arrived ##1 app_m ##1 app_m |-> tx_nd_pin)
        else $error("new data flag not raised");
    sock_clear_a: assert property (app_m && |sock.read_done && !(|sock.arrived)
        ##1 app_m && !(|sock.arrived) ##1 app_m |-> !tx_nd_pin) else $error("new data flag kept");
    bridge_exit_a: assert property (mode_valid && bridge_active && $fell(mode_strap_n)
        |-> ##[1:5] bridge_exit) else $error("bridge exit missing");
    ab_pulse_a: assert property (autobaud_start |-> !field_reprogram_mode
        ##1 mode_valid && !autobaud_start) else $error("autobaud pulse wrong");
    mon_released_a: assert property (field_reprogram_mode |-> !rx_hb_pin_oe)
        else $error("shared pin pulled in monitor mode");
    mon_hold_a: assert property ($rose(field_reprogram_mode)
        |-> low_q >= msrh_pkg::STRAP_HOLD_CYC) else $error("monitor entered early");
    mon_tx_a: assert property (field_reprogram_mode && $past(field_reprogram_mode)
        |-> tx_nd_pin == $past(app.tx)) else $error("monitor transmit wrong");
    rx_idle_a: assert property (!field_reprogram_mode |-> prog_serial_rx)
        else $error("receive not idle outside monitor");
    hard_clear_a: assert property (!hard_reset_n [*3] |=> !mode_valid && tx_nd_pin
        && prog_serial_rx && !rx_hb_pin_oe && !field_reprogram_mode) else $error("not cleared");
endmodule : msrh_props
bind msrh_top msrh_props props_u (.mclk, .rst, .hard_reset_n, .mode_strap_n, .bridge_active,
    .sock, .app, .rx_hb_pin_o, .rx_hb_pin_oe, .tx_nd_pin, .prog_serial_rx,
    .field_reprogram_mode, .autobaud_start, .bridge_exit, .mode_valid);

// ---- msrh_top_tb.sv ----
// Self-checking bench for the strap, reset and heartbeat block
`timescale 1ns/1ps
module msrh_top_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic mode_strap_n = 1'b1;
    logic bridge_active = 1'b0;
    logic reset_req = 1'b0;
    msrh_pkg::msrh_sock_t sock = '0;
    msrh_pkg::msrh_app_t  app = 2'h1;
    logic hard_reset_n, rx_hb_pin_i, rx_hb_pin_o, rx_hb_pin_oe, tx_nd_pin, prog_serial_rx;
    logic field_reprogram_mode, autobaud_start, bridge_exit, mode_valid;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    msrh_top dut_u (.mclk, .rst, .hard_reset_n, .mode_strap_n, .rx_hb_pin_i, .bridge_active,
        .sock, .app, .rx_hb_pin_o, .rx_hb_pin_oe, .tx_nd_pin, .prog_serial_rx,
        .field_reprogram_mode, .autobaud_start, .bridge_exit, .mode_valid);
    msrh_board board_u (.mclk, .rx_hb_pin_oe, .reset_req, .hard_reset_n, .rx_hb_pin_i);
    always #25 mclk = ~mclk;
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // Hang guard, far above the planned run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk
    task cy(input int n); repeat (n) @(posedge mclk); endtask : cy
    task smp; @(negedge mclk); endtask : smp
    task t_app;
        for (int i = 0; i < 60 && mode_valid !== 1'b1; i++) smp();
        chk("monitor", 1'b0, field_reprogram_mode);
        cy(3); smp();
        chk("hb_oe", 1'b1, rx_hb_pin_oe);
        chk("hb_wire", 1'b0, rx_hb_pin_i);
        chk("hb_o", 1'b0, rx_hb_pin_o);
        cy(3000); smp();
        chk("hb_half", 1'b1, rx_hb_pin_oe);
        cy(1); app.fw_ok <= 1'b0;
        cy(3); smp();
        chk("hb_stop", 1'b0, rx_hb_pin_oe);
        cy(1); app.fw_ok <= 1'b1;
    endtask : t_app
    task t_sock;
        cy(1); sock.arrived <= 10'h008;
        cy(1); sock.arrived <= 10'h000;
        cy(1); smp();
        chk("nd_set", 1'b1, tx_nd_pin);
        cy(1); sock <= 20'h80200;
        cy(1); sock <= '0;
        cy(1); smp();
        chk("nd_same", 1'b1, tx_nd_pin);
        cy(1); sock.read_done <= 10'h020;
        cy(1); sock.read_done <= 10'h000;
        cy(1); smp();
        chk("nd_clr", 1'b0, tx_nd_pin);
    endtask : t_sock
    task t_bridge;
        cy(1); bridge_active <= 1'b1; mode_strap_n <= 1'b0;
        for (int i = 0; i < 10 && bridge_exit !== 1'b1; i++) smp();
        chk("exit", 1'b1, bridge_exit);
        smp();
        chk("exit_end", 1'b0, bridge_exit);
        chk("mode_kept", 1'b1, mode_valid);
        cy(1); bridge_active <= 1'b0; mode_strap_n <= 1'b1;
    endtask : t_bridge
    task t_hard_baud;
        cy(5); mode_strap_n <= 1'b0; reset_req <= 1'b1;
        cy(1); reset_req <= 1'b0;
        cy(4); smp();
        chk("clr_valid", 1'b0, mode_valid);
        chk("clr_nd", 1'b1, tx_nd_pin);
        chk("clr_rx", 1'b1, prog_serial_rx);
        cy(100); smp();
        chk("wait_valid", 1'b0, mode_valid);
        cy(1); mode_strap_n <= 1'b1;
        for (int i = 0; i < 10 && autobaud_start !== 1'b1; i++) smp();
        chk("baud", 1'b1, autobaud_start);
        smp();
        chk("baud_valid", 1'b1, mode_valid);
        chk("baud_end", 1'b0, autobaud_start);
        chk("baud_mon", 1'b0, field_reprogram_mode);
        chk("baud_nd", 1'b0, tx_nd_pin);
    endtask : t_hard_baud
    initial begin
        cy(10); rst <= 1'b0;
        t_app();
        t_sock();
        t_bridge();
        t_hard_baud();
        report_and_stop();
    end
endmodule : msrh_top_tb
